// ===== ecppr_pkg.sv
package ecppr_pkg;

    // System clock rate
    localparam int unsigned CLK_MHZ = 50;

    // Register offsets inside the port's I/O window
    localparam logic [10:0] OFS_ADDR_QUEUE = 11'h000;
    localparam logic [10:0] OFS_STATUS = 11'h001;
    localparam logic [10:0] OFS_CONTROL = 11'h002;
    localparam logic [10:0] OFS_DATA_QUEUE = 11'h400;
    localparam logic [10:0] OFS_EXT_MODE = 11'h402;

    // Control register field positions
    localparam int unsigned CTRL_DIR = 5;
    localparam int unsigned CTRL_ACK_IRQ_ENABLE = 4;
    localparam int unsigned CTRL_SELIN = 3;
    localparam int unsigned CTRL_INIT = 2;
    localparam int unsigned CTRL_AUTOFD = 1;
    localparam int unsigned CTRL_STROBE = 0;
    localparam logic [5:0] CTRL_RESET = 6'h00;

    // Status register field positions
    localparam int unsigned STAT_BUSY = 7;
    localparam int unsigned STAT_ACK = 6;
    localparam int unsigned STAT_PERR = 5;
    localparam int unsigned STAT_SEL = 4;
    localparam int unsigned STAT_FAULT = 3;
    localparam int unsigned STAT_IRQ = 2;

    // Extended mode register field positions
    localparam int unsigned EXT_MODE_LSB = 5;
    localparam int unsigned EXT_FULL = 1;
    localparam int unsigned EXT_EMPTY = 0;

    // Port queue geometry
    localparam int unsigned QUEUE_DEPTH = 16;
    localparam int unsigned QUEUE_AW = 4;

    // Handshake timing
    localparam int unsigned SETUP_NS = 500;
    localparam int unsigned STROBE_NS = 1000;
    localparam logic [7:0] SETUP_CYC = 8'((SETUP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] STROBE_CYC = 8'((STROBE_NS * CLK_MHZ + 999) / 1000);

    // Operating modes
    typedef enum logic [2:0] {
        MODE_STD = 3'b000,
        MODE_PS2 = 3'b001,
        MODE_COMPAT_FIFO = 3'b010,
        MODE_ECP = 3'b011,
        MODE_RSV4 = 3'b100,
        MODE_RSV5 = 3'b101,
        MODE_TEST = 3'b110,
        MODE_CONFIG = 3'b111
    } ecppr_mode_t;

    // Handshake engine states
    typedef enum logic [2:0] {
        XF_IDLE = 3'b000,
        XF_SETUP = 3'b001,
        XF_STROBE = 3'b010,
        XF_RELEASE = 3'b011
    } ecppr_xfer_t;

    // One queued byte with its channel/run-length marker
    typedef struct packed {
        logic is_cmd;
        logic [7:0] value;
    } ecppr_entry_t;

    // Peripheral-driven status lines
    typedef struct packed {
        logic busy;
        logic ack_n;
        logic perror;
        logic select;
        logic fault_n;
    } ecppr_lines_t;

endpackage : ecppr_pkg

// ===== ecppr_queue.sv
`timescale 1ns/1ps
module ecppr_queue #(
    parameter int unsigned W = 9,
    parameter int unsigned DEPTH = 16,
    parameter int unsigned AW = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic push_i,
    input wire logic [W-1:0] push_data_i,
    output logic full_o,
    output logic empty_o,
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);

    logic [W-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic [AW:0] nxt_count;
    logic out_valid_ff;
    logic [W-1:0] out_data_ff;
    logic push_go;
    logic pop_go;

    // Push drops when full; pop refills the registered head
    assign push_go = push_i && (count_ff != (AW+1)'(DEPTH));
    assign pop_go = (count_ff != '0) && (!out_valid_ff || out_ready_i);
    assign nxt_count = count_ff + (AW+1)'(push_go) - (AW+1)'(pop_go);

    // Storage array
    always_ff @(posedge clk_i) begin
        if (push_go) begin
            mem_ff[wr_ptr_ff] <= push_data_i;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            wr_ptr_ff <= wr_ptr_ff + AW'(push_go);
            rd_ptr_ff <= rd_ptr_ff + AW'(pop_go);
            count_ff <= nxt_count;
        end
    end

    // Registered read port
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_valid_ff <= 1'b0;
            out_data_ff <= '0;
        end else if (pop_go) begin
            out_valid_ff <= 1'b1;
            out_data_ff <= mem_ff[rd_ptr_ff];
        end else if (out_ready_i) begin
            out_valid_ff <= 1'b0;
        end
    end

    assign full_o = (count_ff == (AW+1)'(DEPTH));
    assign empty_o = (count_ff == '0) && !out_valid_ff;
    assign out_valid_o = out_valid_ff;
    assign out_data_o = out_data_ff;

endmodule : ecppr_queue

// ===== ecppr_skid.sv
`timescale 1ns/1ps
module ecppr_skid #(
    parameter int unsigned W = 9
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);

    logic [W-1:0] head_ff;
    logic [W-1:0] tail_ff;
    logic [1:0] cnt_ff;
    logic in_go;
    logic out_go;

    assign in_ready_o = (cnt_ff != 2'h2);
    assign out_valid_o = (cnt_ff != 2'h0);
    assign out_data_o = head_ff;
    assign in_go = in_valid_i && in_ready_o;
    assign out_go = out_valid_o && out_ready_i;

    // Two slots, head always presented to the drain side
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            head_ff <= '0;
            tail_ff <= '0;
            cnt_ff <= 2'h0;
        end else begin
            case ({in_go, out_go})
                2'b10: begin
                    if (cnt_ff == 2'h0) begin
                        head_ff <= in_data_i;
                    end else begin
                        tail_ff <= in_data_i;
                    end
                    cnt_ff <= cnt_ff + 2'h1;
                end
                2'b01: begin
                    head_ff <= tail_ff;
                    cnt_ff <= cnt_ff - 2'h1;
                end
                2'b11: begin
                    if (cnt_ff == 2'h1) begin
                        head_ff <= in_data_i;
                    end else begin
                        head_ff <= tail_ff;
                        tail_ff <= in_data_i;
                    end
                end
                default: begin
                    cnt_ff <= cnt_ff;
                end
            endcase
        end
    end

endmodule : ecppr_skid

// ===== ecppr_regs.sv
// Behaviour
// - In ECP mode a write at offset 00h queues the byte for sending.
// - Autofeed is asserted low for address/run-length bytes, high for plain data bytes.
// - Status bit 7 reads the inverse of the busy line.
// - Status bit 6 follows the acknowledge line, low while it is asserted.
// - Status bit 5 reads 1 while paper error is asserted.
// - Status bit 4 reads 1 while select is asserted, in every mode.
// - Status bit 3 follows the fault line, low while it is asserted.
// - Status bit 2 always reads 1; bits 1 and 0 read zero.
// - Control bit 5 sets data direction, 0 drives the lines; writable bits reset to zero.
// - With control bit 4 set, an asserted acknowledge raises the interrupt.
// - Control bit 3 set asserts select-in low; clear negates it.
// - Control bit 2 set keeps init negated; clear asserts init.
// - In FIFO and ECP modes control bits 1 and 0 have no effect.
// - In compatible FIFO mode bytes at offset 400h go out with strobe handshake.
// - Three-bit mode field in the extended mode register selects the operating mode.
// - Mode-gated registers respond only while the mode field matches.
`timescale 1ns/1ps
module ecppr_regs (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cs_i,
    input wire logic aen_i,
    input wire logic [10:0] addr_i,
    input wire logic ior_n_i,
    input wire logic iow_n_i,
    input wire logic [7:0] sd_i,
    output logic [7:0] sd_o,
    output logic sd_oe_o,
    input wire ecppr_pkg::ecppr_lines_t lines_i,
    input wire logic [7:0] pd_i,
    output logic [7:0] pd_o,
    output logic pd_oe_o,
    output logic strobe_n_o,
    output logic autofd_n_o,
    output logic selectin_n_o,
    output logic init_n_o,
    output logic irq_o
);

    // Host-side state
    logic iow_prev_ff;
    logic [5:0] ctrl_ff;
    ecppr_pkg::ecppr_mode_t mode_ff;
    logic [7:0] sd_ff;
    logic sd_oe_ff;
    logic [7:0] last_pd_in_ff;

    // Link-side state
    ecppr_pkg::ecppr_xfer_t xfer_ff;
    ecppr_pkg::ecppr_xfer_t nxt_xfer;
    logic [7:0] timer_ff;
    logic [7:0] nxt_timer;
    ecppr_pkg::ecppr_entry_t cur_ff;
    logic pd_oe_ff;
    logic strobe_n_ff;
    logic autofd_n_ff;
    logic selectin_n_ff;
    logic init_n_ff;
    logic irq_ff;

    // Decode and datapath nets
    logic port_sel;
    logic wr_stb;
    logic rd_act;
    logic hit_addr_queue;
    logic hit_status;
    logic hit_control;
    logic hit_data_queue;
    logic hit_ext_mode;
    logic mapped;
    logic [7:0] rd_mux;
    logic [7:0] status_val;
    logic hw_mode;
    logic forward;
    logic push;
    ecppr_pkg::ecppr_entry_t push_entry;
    logic q_full;
    logic q_empty;
    logic q_valid;
    ecppr_pkg::ecppr_entry_t q_data;
    logic buf_ready;
    logic buf_valid;
    ecppr_pkg::ecppr_entry_t buf_data;
    logic take;

    // Port select and bus strobes
    assign port_sel = cs_i && !aen_i;
    assign wr_stb = port_sel && iow_prev_ff && !iow_n_i;
    assign rd_act = port_sel && !ior_n_i;

    // Register decode with mode gating
    assign hit_addr_queue = (addr_i == ecppr_pkg::OFS_ADDR_QUEUE)
        && (mode_ff == ecppr_pkg::MODE_ECP);
    assign hit_data_queue = (addr_i == ecppr_pkg::OFS_DATA_QUEUE)
        && (mode_ff == ecppr_pkg::MODE_COMPAT_FIFO);
    assign hit_status = (addr_i == ecppr_pkg::OFS_STATUS);
    assign hit_control = (addr_i == ecppr_pkg::OFS_CONTROL);
    assign hit_ext_mode = (addr_i == ecppr_pkg::OFS_EXT_MODE);
    assign mapped = hit_addr_queue || hit_data_queue || hit_status || hit_control
        || hit_ext_mode;

    // Hardware handshake owns strobe and autofeed in these modes
    assign hw_mode = (mode_ff == ecppr_pkg::MODE_ECP)
        || (mode_ff == ecppr_pkg::MODE_COMPAT_FIFO);
    assign forward = !ctrl_ff[ecppr_pkg::CTRL_DIR];

    // Write edge detector on the write strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            iow_prev_ff <= 1'b1;
        end else begin
            iow_prev_ff <= iow_n_i;
        end
    end

    // Control register; status writes fall through untouched
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= ecppr_pkg::CTRL_RESET;
        end else if (wr_stb && hit_control) begin
            ctrl_ff <= sd_i[5:0];
        end
    end

    // Mode field of the extended mode register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_ff <= ecppr_pkg::MODE_STD;
        end else if (wr_stb && hit_ext_mode) begin
            mode_ff <= ecppr_pkg::ecppr_mode_t'(sd_i[ecppr_pkg::EXT_MODE_LSB +: 3]);
        end
    end

    // Queue writes: address/run-length bytes are tagged, bit 7 passes untouched
    assign push = wr_stb && (hit_addr_queue || hit_data_queue);
    assign push_entry.is_cmd = hit_addr_queue;
    assign push_entry.value = sd_i;

    // Port queue of sixteen bytes
    ecppr_queue #(
        .W($bits(ecppr_pkg::ecppr_entry_t)),
        .DEPTH(ecppr_pkg::QUEUE_DEPTH),
        .AW(ecppr_pkg::QUEUE_AW)
    ) u_queue (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .push_i(push),
        .push_data_i(push_entry),
        .full_o(q_full),
        .empty_o(q_empty),
        .out_valid_o(q_valid),
        .out_data_o(q_data),
        .out_ready_i(buf_ready)
    );

    // Two-slot buffer between queue and handshake engine
    ecppr_skid #(
        .W($bits(ecppr_pkg::ecppr_entry_t))
    ) u_skid (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(q_valid),
        .in_data_i(q_data),
        .in_ready_o(buf_ready),
        .out_valid_o(buf_valid),
        .out_data_o(buf_data),
        .out_ready_i(take)
    );

    // Status image of the peripheral lines
    always_comb begin
        status_val = 8'h00;
        status_val[ecppr_pkg::STAT_BUSY] = !lines_i.busy;
        status_val[ecppr_pkg::STAT_ACK] = lines_i.ack_n;
        status_val[ecppr_pkg::STAT_PERR] = lines_i.perror;
        status_val[ecppr_pkg::STAT_SEL] = lines_i.select;
        status_val[ecppr_pkg::STAT_FAULT] = lines_i.fault_n;
        status_val[ecppr_pkg::STAT_IRQ] = 1'b1;
    end

    // Read data selection
    always_comb begin
        rd_mux = 8'h00;
        if (hit_status) begin
            rd_mux = status_val;
        end else if (hit_control) begin
            rd_mux = {2'b00, ctrl_ff};
        end else if (hit_ext_mode) begin
            rd_mux[ecppr_pkg::EXT_MODE_LSB +: 3] = mode_ff;
            rd_mux[ecppr_pkg::EXT_FULL] = q_full;
            rd_mux[ecppr_pkg::EXT_EMPTY] = q_empty;
        end else begin
            rd_mux = 8'h00;
        end
    end

    // Host read drivers; unmapped addresses leave the bus undriven
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sd_ff <= 8'h00;
            sd_oe_ff <= 1'b0;
        end else begin
            sd_ff <= rd_mux;
            sd_oe_ff <= rd_act && mapped;
        end
    end

    // Last byte seen on the data lines in reverse direction
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_pd_in_ff <= 8'h00;
        end else if (!forward) begin
            last_pd_in_ff <= pd_i;
        end
    end

    // Engine takes a byte when idle, forward and the peripheral is free
    assign take = (xfer_ff == ecppr_pkg::XF_IDLE) && hw_mode && forward
        && !lines_i.busy && buf_valid;

    // Handshake engine next state
    always_comb begin
        nxt_xfer = xfer_ff;
        nxt_timer = timer_ff;
        case (xfer_ff)
            ecppr_pkg::XF_IDLE: begin
                if (take) begin
                    nxt_xfer = ecppr_pkg::XF_SETUP;
                    nxt_timer = ecppr_pkg::SETUP_CYC;
                end
            end
            ecppr_pkg::XF_SETUP: begin
                if (timer_ff == 8'h01) begin
                    nxt_xfer = ecppr_pkg::XF_STROBE;
                    nxt_timer = ecppr_pkg::STROBE_CYC;
                end else begin
                    nxt_timer = timer_ff - 8'h01;
                end
            end
            ecppr_pkg::XF_STROBE: begin
                // ECP waits for busy high; compatible uses a timed strobe
                if (timer_ff != 8'h01) begin
                    nxt_timer = timer_ff - 8'h01;
                end else if ((mode_ff != ecppr_pkg::MODE_ECP) || lines_i.busy) begin
                    nxt_xfer = ecppr_pkg::XF_RELEASE;
                end
            end
            ecppr_pkg::XF_RELEASE: begin
                if (!lines_i.busy) begin
                    nxt_xfer = ecppr_pkg::XF_IDLE;
                end
            end
            default: begin
                nxt_xfer = ecppr_pkg::XF_IDLE;
                nxt_timer = 8'h00;
            end
        endcase
    end

    // Handshake engine state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            xfer_ff <= ecppr_pkg::XF_IDLE;
            timer_ff <= 8'h00;
        end else begin
            xfer_ff <= nxt_xfer;
            timer_ff <= nxt_timer;
        end
    end

    // Byte held on the data lines for the current transfer
    // Loaded only from idle, so data cannot move while strobe is low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur_ff <= '0;
        end else if (take) begin
            cur_ff <= buf_data;
        end
    end

    // Data lines and their direction
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pd_oe_ff <= 1'b1;
        end else begin
            pd_oe_ff <= forward;
        end
    end

    // Strobe and autofeed: hardware owned in FIFO modes, software otherwise
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strobe_n_ff <= 1'b1;
            autofd_n_ff <= 1'b1;
        end else if (hw_mode) begin
            strobe_n_ff <= !(nxt_xfer == ecppr_pkg::XF_STROBE);
            if (take) begin
                autofd_n_ff <= !((mode_ff == ecppr_pkg::MODE_ECP) && buf_data.is_cmd);
            end else if (xfer_ff == ecppr_pkg::XF_IDLE) begin
                autofd_n_ff <= 1'b1;
            end
        end else begin
            strobe_n_ff <= !ctrl_ff[ecppr_pkg::CTRL_STROBE];
            autofd_n_ff <= !ctrl_ff[ecppr_pkg::CTRL_AUTOFD];
        end
    end

    // Select-in and init follow the control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            selectin_n_ff <= 1'b1;
            init_n_ff <= 1'b0;
        end else begin
            selectin_n_ff <= !ctrl_ff[ecppr_pkg::CTRL_SELIN];
            init_n_ff <= ctrl_ff[ecppr_pkg::CTRL_INIT];
        end
    end

    // Interrupt request while acknowledge is asserted and enabled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= ctrl_ff[ecppr_pkg::CTRL_ACK_IRQ_ENABLE] && !lines_i.ack_n;
        end
    end

    // Output pins straight from flops
    assign sd_o = sd_ff;
    assign sd_oe_o = sd_oe_ff;
    assign pd_o = cur_ff.value;
    assign pd_oe_o = pd_oe_ff;
    assign strobe_n_o = strobe_n_ff;
    assign autofd_n_o = autofd_n_ff;
    assign selectin_n_o = selectin_n_ff;
    assign init_n_o = init_n_ff;
    assign irq_o = irq_ff;

endmodule : ecppr_regs

// ===== ecppr_chk.sv
`timescale 1ns/1ps
module ecppr_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cs_i,
    input wire logic aen_i,
    input wire logic [10:0] addr_i,
    input wire logic ior_n_i,
    input wire logic [7:0] sd_o,
    input wire logic sd_oe_o,
    input wire ecppr_pkg::ecppr_lines_t lines_i,
    input wire logic [7:0] pd_o,
    input wire logic pd_oe_o,
    input wire logic strobe_n_o,
    input wire logic autofd_n_o,
    input wire logic selectin_n_o,
    input wire logic init_n_o,
    input wire logic irq_o
);
    logic [7:0] low_cnt_ff;

    // Counts cycles with strobe held low
    always_ff @(posedge clk_i) begin
        if (rst_i || strobe_n_o) begin
            low_cnt_ff <= 8'h00;
        end else if (low_cnt_ff != 8'hff) begin
            low_cnt_ff <= low_cnt_ff + 8'h01;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Host read of the status offset
    sequence s_stat_rd;
        cs_i && !aen_i && !ior_n_i && addr_i == ecppr_pkg::OFS_STATUS;
    endsequence

    a_stat_busy: assert property (s_stat_rd |=> sd_oe_o && sd_o[7] == !$past(lines_i.busy))
        else $error("status busy bit wrong");
    a_stat_ack: assert property (s_stat_rd |=> sd_o[6] == $past(lines_i.ack_n))
        else $error("status ack bit wrong");
    a_stat_lines: assert property (s_stat_rd |=> sd_o[5:3] == $past(lines_i[2:0]))
        else $error("status perror/select/fault bits wrong");
    a_stat_fixed: assert property (s_stat_rd |=> sd_o[2:0] == 3'b100)
        else $error("status low bits wrong");
    a_irq_cause: assert property (irq_o |-> !$past(lines_i.ack_n))
        else $error("interrupt without acknowledge");
    a_reset_lines: assert property ($past(rst_i) |-> !init_n_o && selectin_n_o && pd_oe_o && !irq_o)
        else $error("port lines wrong after reset");
    a_strobe_width: assert property ($rose(strobe_n_o) |-> low_cnt_ff >= 8'h32)
        else $error("strobe pulse too short");
    a_pd_hold: assert property (!strobe_n_o && !$past(strobe_n_o) |-> $stable(pd_o) && $stable(autofd_n_o))
        else $error("data or autofeed moved under strobe");
    a_fwd_only: assert property ($fell(strobe_n_o) |-> pd_oe_o)
        else $error("strobe while data lines not driven");
    a_no_read_quiet: assert property ($past(ior_n_i) |-> !sd_oe_o)
        else $error("host bus driven without read");
endmodule : ecppr_chk

// ===== ecppr_periph.sv
`timescale 1ns/1ps
module ecppr_periph (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] lag_i,
    input wire logic strobe_n_i,
    input wire logic autofd_n_i,
    input wire logic [7:0] pd_i,
    output logic busy_o,
    output logic ack_n_o
);
    logic [8:0] got_q[$];
    int cnt;

    // Busy follows strobe after lag cycles; ack pulses as a byte completes
    always @(posedge clk_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
            ack_n_o <= 1'b1;
            cnt = 0;
        end else if (busy_o == strobe_n_i) begin
            cnt = cnt + 1;
            if (cnt >= int'(lag_i)) begin
                cnt = 0;
                busy_o <= !busy_o;
                ack_n_o <= !busy_o;
                if (!busy_o) begin
                    got_q.push_back({autofd_n_i, pd_i}); // Bit 7 kind left to reader
                end
            end
        end else begin
            cnt = 0;
            ack_n_o <= 1'b1;
        end
    end
endmodule : ecppr_periph

// ===== tb.sv
`timescale 1ns/1ps
module tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cs_i = 1'b0;
    logic aen_i = 1'b0;
    logic [10:0] addr_i = 11'h000;
    logic ior_n_i = 1'b1;
    logic iow_n_i = 1'b1;
    logic [7:0] sd_i = 8'h00;
    logic [7:0] sd_o, pd_o, pd_w;
    logic sd_oe_o, pd_oe_o, strobe_n_o, autofd_n_o, selectin_n_o, init_n_o, irq_o;
    logic p_busy, p_ack_n;
    logic pat = 1'b0;
    logic [4:0] lv = 5'b01001;
    logic [7:0] lag = 8'h03;
    ecppr_pkg::ecppr_lines_t lines_i;
    int failures = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [8:0] exp_q[$];

    // Line levels seen by the port; released data lines toggle
    assign lines_i = {lv[4] | p_busy, lv[3] & p_ack_n, lv[2:0]};
    assign pd_w = pd_oe_o ? pd_o : {8{pat}};

    ecppr_regs ecppr_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .cs_i(cs_i), .aen_i(aen_i),
        .addr_i(addr_i), .ior_n_i(ior_n_i), .iow_n_i(iow_n_i), .sd_i(sd_i), .sd_o(sd_o),
        .sd_oe_o(sd_oe_o), .lines_i(lines_i), .pd_i(pd_w), .pd_o(pd_o), .pd_oe_o(pd_oe_o),
        .strobe_n_o(strobe_n_o), .autofd_n_o(autofd_n_o), .selectin_n_o(selectin_n_o),
        .init_n_o(init_n_o), .irq_o(irq_o));
    ecppr_periph ecppr_periph_inst (.clk_i(clk_i), .rst_i(rst_i), .lag_i(lag),
        .strobe_n_i(strobe_n_o), .autofd_n_i(autofd_n_o), .pd_i(pd_w), .busy_o(p_busy),
        .ack_n_o(p_ack_n));

    // Clock
    always #10 clk_i = ~clk_i;

    // Hang guard and line pattern
    always @(posedge clk_i) begin
        pat <= ~pat;
        cyc++;
        if (cyc == 60000) begin
            failures++;
            complete_run();
        end
    end

    task automatic chk(string what, logic [8:0] exp, logic [8:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(logic [10:0] a, logic [7:0] d);
        @(posedge clk_i);
        #1 {cs_i, addr_i, sd_i, iow_n_i} = {1'b1, a, d, 1'b0};
        @(posedge clk_i);
        #1 {cs_i, iow_n_i} = 2'b01;
    endtask : wr

    task automatic rd_chk(string what, logic [10:0] a, logic [7:0] m, logic [8:0] exp);
        @(posedge clk_i);
        #1 {cs_i, addr_i, ior_n_i} = {1'b1, a, 1'b0};
        @(posedge clk_i);
        #1 chk(what, exp, {sd_oe_o, sd_o & m});
        {cs_i, ior_n_i} = 2'b01;
    endtask : rd_chk

    task automatic drain();
        for (int i = 0; i < 5000 && ecppr_periph_inst.got_q.size() < exp_q.size(); i++) begin
            @(posedge clk_i);
        end
        repeat (200) @(posedge clk_i);
        chk("sent count", 9'(exp_q.size()), 9'(ecppr_periph_inst.got_q.size()));
        while (exp_q.size() > 0 && ecppr_periph_inst.got_q.size() > 0) begin
            chk("sent byte", exp_q.pop_front(), ecppr_periph_inst.got_q.pop_front());
        end
    endtask : drain

    task automatic t_reset();
        chk("idle lines", 9'h01d, {4'h0, strobe_n_o, autofd_n_o, selectin_n_o, init_n_o, pd_oe_o});
        rd_chk("control", ecppr_pkg::OFS_CONTROL, 8'h3f, 9'h100);
        rd_chk("ext mode", ecppr_pkg::OFS_EXT_MODE, 8'hff, 9'h101);
        rd_chk("unmapped", 11'h003, 8'h00, 9'h000);
    endtask : t_reset

    task automatic t_status();
        for (int i = 0; i < 6; i++) begin
            lv = (5'h01 << i) ^ 5'b01001;
            rd_chk("status", ecppr_pkg::OFS_STATUS, 8'hff, {1'b1, ~lv[4], lv[3:0], 3'b100});
        end
        lv = 5'b01001;
        wr(ecppr_pkg::OFS_STATUS, 8'hff);
        rd_chk("control", ecppr_pkg::OFS_CONTROL, 8'h3f, 9'h100);
        chk("lines", 9'h005, {6'h00, selectin_n_o, init_n_o, pd_oe_o});
    endtask : t_status

    task automatic t_control();
        wr(ecppr_pkg::OFS_CONTROL, 8'h08);
        repeat (2) @(posedge clk_i);
        #1 chk("select/init", 9'h000, {7'h00, selectin_n_o, init_n_o});
        wr(ecppr_pkg::OFS_CONTROL, 8'h24);
        repeat (2) @(posedge clk_i);
        #1 chk("select/init/dir", 9'h006, {6'h00, selectin_n_o, init_n_o, pd_oe_o});
        rd_chk("control", ecppr_pkg::OFS_CONTROL, 8'h3f, 9'h124);
        wr(ecppr_pkg::OFS_CONTROL, 8'h14);
        lv[3] = 1'b0;
        repeat (3) @(posedge clk_i);
        #1 chk("irq on", 9'h001, {8'h00, irq_o});
        wr(ecppr_pkg::OFS_CONTROL, 8'h04);
        repeat (3) @(posedge clk_i);
        #1 chk("irq off", 9'h000, {8'h00, irq_o});
        lv[3] = 1'b1;
    endtask : t_control

    task automatic t_ecp();
        lag = 8'h3c;
        wr(ecppr_pkg::OFS_EXT_MODE, 8'h60);
        wr(ecppr_pkg::OFS_CONTROL, 8'h07);
        repeat (3) @(posedge clk_i);
        #1 chk("handshake idle", 9'h003, {7'h00, strobe_n_o, autofd_n_o});
        wr(ecppr_pkg::OFS_ADDR_QUEUE, 8'h85);
        wr(ecppr_pkg::OFS_ADDR_QUEUE, 8'h05);
        wr(ecppr_pkg::OFS_DATA_QUEUE, 8'h77);
        exp_q = '{9'h085, 9'h005};
        drain();
    endtask : t_ecp

    task automatic t_compat();
        logic [7:0] b;
        lag = 8'h03;
        wr(ecppr_pkg::OFS_EXT_MODE, 8'h40);
        wr(ecppr_pkg::OFS_CONTROL, 8'h24);
        for (int i = 0; i < 19; i++) begin
            b = 8'h10 + 8'(i);
            wr(ecppr_pkg::OFS_DATA_QUEUE, b);
            exp_q.push_back({1'b1, b});
        end
        wr(ecppr_pkg::OFS_ADDR_QUEUE, 8'h99);
        rd_chk("full", ecppr_pkg::OFS_EXT_MODE, 8'h03, 9'h102);
        chk("held", 9'h100, {strobe_n_o, 8'(ecppr_periph_inst.got_q.size())});
        wr(ecppr_pkg::OFS_CONTROL, 8'h04); // Forward before sending
        drain();
        rd_chk("empty", ecppr_pkg::OFS_EXT_MODE, 8'h03, 9'h101);
    endtask : t_compat

    task automatic complete_run();
        if (failures == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    // Main sequence
    initial begin
        repeat (4) @(posedge clk_i);
        #1 rst_i = 1'b0;
        t_reset();
        t_status();
        t_control();
        t_ecp();
        t_compat();
        complete_run();
    end
endmodule : tb

bind ecppr_regs ecppr_chk ecppr_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .cs_i(cs_i),
    .aen_i(aen_i), .addr_i(addr_i), .ior_n_i(ior_n_i), .sd_o(sd_o), .sd_oe_o(sd_oe_o),
    .lines_i(lines_i), .pd_o(pd_o), .pd_oe_o(pd_oe_o), .strobe_n_o(strobe_n_o),
    .autofd_n_o(autofd_n_o), .selectin_n_o(selectin_n_o), .init_n_o(init_n_o),
    .irq_o(irq_o));
